// ==== hdl/pec_pkg.sv ====
// constants and types for the enable and configuration register bank
package pec_pkg;

    localparam logic [7:0] REG_ENABLES_ADDR  = 8'h12;
    localparam logic [7:0] REG_CONFIG_ADDR   = 8'h13;
    localparam logic [7:0] REG_PASSWORD_ADDR = 8'h10;
    localparam logic [7:0] ENABLES_RESET     = 8'h00;
    localparam logic [7:0] CONFIG_RESET      = 8'h48;
    localparam logic [7:0] ENABLES_WMASK     = 8'h7f;

    // rail_and_output_enables fields
    localparam int EN_LINEAR_REG  = 0;
    localparam int EN_SWITCH_ONE  = 1;
    localparam int EN_SWITCH_TWO  = 2;
    localparam int EN_SWITCH_THREE = 3;
    localparam int EN_FIRST_GP    = 4;
    localparam int EN_SECOND_GP   = 5;
    localparam int EN_THIRD_GP    = 6;

    // io_and_supervisor_config fields
    localparam int CF_UNDERVOLTAGE_LOCKOUT_THRESHOLD_LSB    = 0;
    localparam int CF_SUPERVISOR_STRICTNESS      = 2;
    localparam int CF_POWER_GOOD_DELAY_SEL_LSB   = 3;
    localparam int CF_PAIRING     = 5;
    localparam int CF_BUF_TYPE    = 6;
    localparam int CF_RESET_TIME  = 7;

    localparam int CLK_HZ         = 100_000_000;
    localparam int RESET_SHORT_S  = 8;
    localparam int RESET_LONG_S   = 15;
    localparam int PG_DLY0_MS     = 10;
    localparam int PG_DLY1_MS     = 20;
    localparam int PG_DLY2_MS     = 50;
    localparam int PG_DLY3_MS     = 150;
    localparam longint RESET_SHORT_CYC = longint'(RESET_SHORT_S) * CLK_HZ;
    localparam longint RESET_LONG_CYC  = longint'(RESET_LONG_S) * CLK_HZ;
    localparam longint PG_DLY0_CYC = longint'(PG_DLY0_MS) * (CLK_HZ / 1000);
    localparam longint PG_DLY1_CYC = longint'(PG_DLY1_MS) * (CLK_HZ / 1000);
    localparam longint PG_DLY2_CYC = longint'(PG_DLY2_MS) * (CLK_HZ / 1000);
    localparam longint PG_DLY3_CYC = longint'(PG_DLY3_MS) * (CLK_HZ / 1000);

    typedef enum logic [1:0] {PEC_PG_LOW, PEC_PG_WAIT, PEC_PG_HIGH} pec_pg_state_t;

endpackage : pec_pkg

// ==== hdl/pec_regs.sv ====
// password-protected rail enable and io/supervisor configuration registers
`timescale 1ns/1ps
module pec_regs #(
    parameter logic [7:0] UNLOCK_KEY     = 8'h7d,
    parameter longint     RESET_SHORT    = pec_pkg::RESET_SHORT_CYC,
    parameter longint     RESET_LONG     = pec_pkg::RESET_LONG_CYC,
    parameter longint     PG_DLY0        = pec_pkg::PG_DLY0_CYC,
    parameter longint     PG_DLY1        = pec_pkg::PG_DLY1_CYC,
    parameter longint     PG_DLY2        = pec_pkg::PG_DLY2_CYC,
    parameter longint     PG_DLY3        = pec_pkg::PG_DLY3_CYC
) (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       seq_update,
    input  wire logic       seq_switch_one,
    input  wire logic       seq_linear_reg,
    input  wire logic       push_button_n,
    input  wire logic       rails_good,
    input  wire logic       first_gp_pin_i,
    output logic            first_gp_pin_o,
    output logic            first_gp_pin_oe,
    output logic            second_gp_output_o,
    output logic            second_gp_output_oe,
    output logic            second_gp_output_push_pull,
    output logic            third_gp_control,
    output logic            switch_one_enable,
    output logic            switch_two_enable,
    output logic            switch_three_enable,
    output logic            linear_reg_enable,
    output logic            power_good,
    output logic            push_button_reset,
    output logic            supervisor_strictness,
    output logic            overvoltage_monitor_en,
    output logic      [1:0] undervoltage_lockout_threshold
);

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0]            enables_ff;
    logic [7:0]            config_ff;
    logic                  unlocked_ff;
    logic [31:0]           pb_cnt_ff;
    logic [31:0]           pg_cnt_ff;
    pec_pkg::pec_pg_state_t pg_state_ff;
    logic                  wr_en;
    logic                  wr_cfg;
    logic                  second_level;
    logic [31:0]           pg_target;
    logic [31:0]           pb_target;

    function automatic logic [31:0] pg_delay(input logic [1:0] sel);
        unique case (sel)
            2'h0: pg_delay = 32'(PG_DLY0);
            2'h1: pg_delay = 32'(PG_DLY1);
            2'h2: pg_delay = 32'(PG_DLY2);
            2'h3: pg_delay = 32'(PG_DLY3);
        endcase
    endfunction : pg_delay

    // both timers compare against a target that software may lower mid-count
    function automatic logic reached(input logic [31:0] cnt, input logic [31:0] lim);
        reached = cnt >= lim;
    endfunction : reached

    // one unlock admits exactly one following write; any other write relocks
    // a wrong key relocks too, so a stray write cannot open the bank by chance
    assign wr_en  = reg_wr && unlocked_ff && reg_addr == pec_pkg::REG_ENABLES_ADDR;
    assign wr_cfg = reg_wr && unlocked_ff && reg_addr == pec_pkg::REG_CONFIG_ADDR;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            unlocked_ff <= 1'b0;
        else if (reg_wr)
            unlocked_ff <= reg_addr == pec_pkg::REG_PASSWORD_ADDR
                           && reg_wdata == UNLOCK_KEY;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer wins over a software write in the same cycle
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            enables_ff <= pec_pkg::ENABLES_RESET;
        else
        begin
            // reserved top bit is never stored, so it always reads back zero
            if (wr_en)
                enables_ff <= reg_wdata & pec_pkg::ENABLES_WMASK;
            if (seq_update)
            begin
                enables_ff[pec_pkg::EN_SWITCH_ONE] <= seq_switch_one;
                enables_ff[pec_pkg::EN_LINEAR_REG] <= seq_linear_reg;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            config_ff <= pec_pkg::CONFIG_RESET;
        else if (wr_cfg)
            config_ff <= reg_wdata;
    end

    // password reads back zero, unmapped reads zero
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= 8'h00;
        else if (reg_rd)
        begin
            if (reg_addr == pec_pkg::REG_ENABLES_ADDR)
                reg_rdata <= enables_ff;
            else if (reg_addr == pec_pkg::REG_CONFIG_ADDR)
                reg_rdata <= config_ff;
            else
                reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            switch_one_enable   <= 1'b0;
            switch_two_enable   <= 1'b0;
            switch_three_enable <= 1'b0;
            linear_reg_enable   <= 1'b0;
        end
        else
        begin
            switch_one_enable   <= enables_ff[pec_pkg::EN_SWITCH_ONE];
            switch_two_enable   <= enables_ff[pec_pkg::EN_SWITCH_TWO];
            switch_three_enable <= enables_ff[pec_pkg::EN_SWITCH_THREE];
            linear_reg_enable   <= enables_ff[pec_pkg::EN_LINEAR_REG];
        end
    end

    // the third pin's reset role is handled elsewhere; only its level bit leaves here
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            third_gp_control <= 1'b0;
        else
            third_gp_control <= enables_ff[pec_pkg::EN_THIRD_GP];
    end

    // pin input is taken as synchronous, so it is used without a synchroniser
    assign second_level = config_ff[pec_pkg::CF_PAIRING] ? first_gp_pin_i
                                                         : enables_ff[pec_pkg::EN_SECOND_GP];

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            first_gp_pin_o  <= 1'b0;
            first_gp_pin_oe <= 1'b0;
        end
        else
        begin
            first_gp_pin_o  <= 1'b0;
            first_gp_pin_oe <= !config_ff[pec_pkg::CF_PAIRING]
                               && !enables_ff[pec_pkg::EN_FIRST_GP];
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            second_gp_output_o  <= 1'b0;
            second_gp_output_oe <= 1'b0;
        end
        else
        begin
            second_gp_output_o  <= second_level;
            // open drain drives only the low level
            second_gp_output_oe <= config_ff[pec_pkg::CF_BUF_TYPE] || !second_level;
        end
    end

    // the buffer type goes out on its own; the pad picks the high-level source from it
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            second_gp_output_push_pull <= 1'b0;
        else
            second_gp_output_push_pull <= config_ff[pec_pkg::CF_BUF_TYPE];
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            supervisor_strictness  <= 1'b0;
            overvoltage_monitor_en <= 1'b0;
        end
        else
        begin
            supervisor_strictness  <= config_ff[pec_pkg::CF_SUPERVISOR_STRICTNESS];
            overvoltage_monitor_en <= config_ff[pec_pkg::CF_SUPERVISOR_STRICTNESS];
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            undervoltage_lockout_threshold <= 2'h0;
        else
            undervoltage_lockout_threshold <= config_ff[pec_pkg::CF_UNDERVOLTAGE_LOCKOUT_THRESHOLD_LSB +: 2];
    end

    assign pg_target = pg_delay(config_ff[pec_pkg::CF_POWER_GOOD_DELAY_SEL_LSB +: 2]);

    // delay counts only on the way up; a drop of rails_good ends it at once
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pg_state_ff <= pec_pkg::PEC_PG_LOW;
            pg_cnt_ff   <= 32'h0;
            power_good  <= 1'b0;
        end
        else if (!rails_good)
        begin
            pg_state_ff <= pec_pkg::PEC_PG_LOW;
            pg_cnt_ff   <= 32'h0;
            power_good  <= 1'b0;
        end
        else
        begin
            unique case (pg_state_ff)
                pec_pkg::PEC_PG_LOW:
                begin
                    pg_state_ff <= pec_pkg::PEC_PG_WAIT;
                    pg_cnt_ff   <= 32'h1;
                end
                pec_pkg::PEC_PG_WAIT:
                begin
                    if (reached(pg_cnt_ff, pg_target))
                    begin
                        pg_state_ff <= pec_pkg::PEC_PG_HIGH;
                        power_good  <= 1'b1;
                    end
                    else
                        pg_cnt_ff <= pg_cnt_ff + 32'h1;
                end
                pec_pkg::PEC_PG_HIGH:
                    power_good <= 1'b1;
                // the spare state code falls back to low
                default:
                    pg_state_ff <= pec_pkg::PEC_PG_LOW;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign pb_target = config_ff[pec_pkg::CF_RESET_TIME] ? 32'(RESET_LONG)
                                                         : 32'(RESET_SHORT);

    // reset pulse is raised once per hold and stays up until the button is released
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            pb_cnt_ff <= 32'h0;
        else if (push_button_n)
            pb_cnt_ff <= 32'h0;
        else if (!reached(pb_cnt_ff, pb_target - 32'h1))
            pb_cnt_ff <= pb_cnt_ff + 32'h1;
    end

    // the counter parks one below its target, so one long press cannot wrap and pulse twice
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            push_button_reset <= 1'b0;
        else if (push_button_n)
            push_button_reset <= 1'b0;
        else if (reached(pb_cnt_ff, pb_target - 32'h1))
            push_button_reset <= 1'b1;
    end

endmodule : pec_regs

// ==== bench/pec_regs_props.sv ====
// port-level assertions for the rail enable and config register bank
`timescale 1ns/1ps
module pec_regs_props #(
    parameter longint RESET_SHORT = 20
) (
    input wire logic       mclk,
    input wire logic       reset_n,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    input wire logic       push_button_n,
    input wire logic       rails_good,
    input wire logic       first_gp_pin_o,
    input wire logic       second_gp_output_o,
    input wire logic       second_gp_output_oe,
    input wire logic       second_gp_output_push_pull,
    input wire logic       power_good,
    input wire logic       push_button_reset,
    input wire logic       supervisor_strictness,
    input wire logic       overvoltage_monitor_en
);
    longint held_ff;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////
    // counts button-low samples; the hold timer may not beat it
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            held_ff <= 0;
        else
            held_ff <= push_button_n ? 0 : held_ff + 1;
    end
    AST_PIN_LOW_ONLY: assert property (first_gp_pin_o == 1'b0)
        else $error("first pin driven high");
    AST_OD_LOW: assert property (!second_gp_output_push_pull && second_gp_output_oe
        |-> !second_gp_output_o) else $error("open drain drove high");
    AST_PP_OE: assert property (second_gp_output_push_pull |-> second_gp_output_oe)
        else $error("push pull not driving");
    AST_OV_MON: assert property (overvoltage_monitor_en == supervisor_strictness)
        else $error("overvoltage monitor mismatch");
    AST_PG_FALL: assert property (!rails_good |=> !power_good)
        else $error("power good fall delayed");
    AST_PG_MIN: assert property ($rose(rails_good) |-> !power_good [*5])
        else $error("power good rose too early");
    AST_PG_MAX: assert property ($rose(rails_good)
        |-> ##[1:45] (power_good || !rails_good)) else $error("power good never rose");
    AST_RD_PW: assert property (reg_rd && reg_addr == pec_pkg::REG_PASSWORD_ADDR
        |=> reg_rdata == 8'h00) else $error("password read not zero");
    AST_HOLD: assert property ($rose(push_button_reset) |-> held_ff >= RESET_SHORT - 1)
        else $error("button reset too early");
    COV_PG: cover property ($rose(power_good));
    COV_BTN: cover property ($rose(push_button_reset));
    COV_OD: cover property ($fell(second_gp_output_push_pull));
endmodule : pec_regs_props

// ==== bench/tb_top.sv ====
// self-checking bench for the rail enable and config register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_top;
    logic       mclk, reset_n, reg_wr, reg_rd, seq_update, seq_switch_one, seq_linear_reg;
    logic       push_button_n, rails_good, first_gp_pin_i, first_gp_pin_o, first_gp_pin_oe;
    logic       second_gp_output_o, second_gp_output_oe, second_gp_output_push_pull;
    logic       third_gp_control, switch_one_enable, switch_two_enable, switch_three_enable;
    logic       linear_reg_enable, power_good, push_button_reset, supervisor_strictness;
    logic       overvoltage_monitor_en, pin, lvl;
    logic [1:0] undervoltage_lockout_threshold;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, en, cf, rdv;
    int         n_mismatch, comparisons, cyc, n;
    // short hold and delay counts keep the run brief
    localparam longint HOLD_SHORT = 20;
    localparam longint HOLD_LONG  = 40;
    localparam longint DLY0       = 5;
    localparam longint DLY1       = 10;
    localparam longint DLY2       = 20;
    localparam longint DLY3       = 40;
    pec_regs #(.RESET_SHORT(HOLD_SHORT), .RESET_LONG(HOLD_LONG), .PG_DLY0(DLY0),
        .PG_DLY1(DLY1), .PG_DLY2(DLY2), .PG_DLY3(DLY3)) pec_regs_i (.mclk, .reset_n,
        .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .seq_update, .seq_switch_one, .seq_linear_reg, .push_button_n,
        .rails_good, .first_gp_pin_i, .first_gp_pin_o, .first_gp_pin_oe, .second_gp_output_o,
        .second_gp_output_oe, .second_gp_output_push_pull, .third_gp_control,
        .switch_one_enable, .switch_two_enable, .switch_three_enable, .linear_reg_enable,
        .power_good, .push_button_reset, .supervisor_strictness, .overvoltage_monitor_en,
        .undervoltage_lockout_threshold);
    ////////////////////////////////////////////////////////////////////////
    function automatic int pgd(input logic [1:0] d);
        return int'((d == 2'h0) ? DLY0 : (d == 2'h1) ? DLY1 : (d == 2'h2) ? DLY2 : DLY3);
    endfunction : pgd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
    endtask : wr
    // unlock first; any other write in between relocks
    task automatic pwr(input logic [7:0] a, input logic [7:0] d);
        wr(pec_pkg::REG_PASSWORD_ADDR, 8'h7d);
        wr(a, d);
        @(negedge mclk);
    endtask : pwr
    task automatic crd(input logic [7:0] a, input logic [7:0] e);
        @(negedge mclk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd = 1'b0;
        `CHK("read", e, reg_rdata)
    endtask : crd
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : summarize
    always #5 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            summarize();
        end
    end
    initial
    begin
        {mclk, reset_n, reg_wr, reg_rd, seq_update, seq_switch_one, seq_linear_reg} = 7'h0;
        {reg_addr, reg_wdata, rails_good, first_gp_pin_i} = 18'h0;
        push_button_n = 1'b1;
        void'($urandom(32'h597a));
        repeat (8) @(posedge mclk);
        @(negedge mclk) reset_n = 1'b1;
        crd(pec_pkg::REG_ENABLES_ADDR, 8'h00);
        crd(pec_pkg::REG_CONFIG_ADDR, 8'h48);
        crd(8'h20, 8'h00);
        wr(pec_pkg::REG_CONFIG_ADDR, 8'h00);
        crd(pec_pkg::REG_CONFIG_ADDR, 8'h48);
        wr(pec_pkg::REG_PASSWORD_ADDR, 8'h7d);
        crd(pec_pkg::REG_PASSWORD_ADDR, 8'h00);
        wr(8'h20, 8'h00);
        wr(pec_pkg::REG_ENABLES_ADDR, 8'hff);
        crd(pec_pkg::REG_ENABLES_ADDR, 8'h00);
        repeat (16)
        begin
            en = 8'($urandom);
            cf = 8'($urandom);
            pin = 1'($urandom);
            first_gp_pin_i = pin;
            pwr(pec_pkg::REG_ENABLES_ADDR, en);
            pwr(pec_pkg::REG_CONFIG_ADDR, cf);
            crd(pec_pkg::REG_ENABLES_ADDR, en & 8'h7f);
            crd(pec_pkg::REG_CONFIG_ADDR, cf);
            `CHK("rails", {en[6], en[3:0]}, {third_gp_control, switch_three_enable,
                switch_two_enable, switch_one_enable, linear_reg_enable})
            `CHK("cfg", {cf[6], cf[2], cf[2], cf[1:0]}, {second_gp_output_push_pull,
                supervisor_strictness, overvoltage_monitor_en,
                undervoltage_lockout_threshold})
            `CHK("pin1_oe", !cf[5] && !en[4], first_gp_pin_oe)
            lvl = cf[5] ? pin : en[5];
            `CHK("pin2_oe", cf[6] || !lvl, second_gp_output_oe)
            if (cf[6])
                `CHK("pin2_o", lvl, second_gp_output_o)
        end
        pwr(pec_pkg::REG_ENABLES_ADDR, 8'h01);
        {seq_update, seq_switch_one, seq_linear_reg} = 3'b110;
        @(negedge mclk) seq_update = 1'b0;
        crd(pec_pkg::REG_ENABLES_ADDR, 8'h02);
        {seq_update, seq_switch_one, seq_linear_reg} = 3'b101;
        @(negedge mclk) seq_update = 1'b0;
        crd(pec_pkg::REG_ENABLES_ADDR, 8'h01);
        `CHK("seq_rails", 2'b01, {switch_one_enable, linear_reg_enable})
        for (int d = 0; d < 4; d++)
        begin
            pwr(pec_pkg::REG_CONFIG_ADDR, {3'h0, 2'(d), 3'h0});
            rails_good = 1'b1;
            n = 0;
            while (power_good !== 1'b1 && n < 100)
                @(negedge mclk) n++;
            `CHK("pg_delay", pgd(2'(d)) + 1, n)
            rails_good = 1'b0;
            @(negedge mclk);
            `CHK("pg_fall", 1'b0, power_good)
        end
        for (int t = 0; t < 2; t++)
        begin
            pwr(pec_pkg::REG_CONFIG_ADDR, t ? 8'hc8 : 8'h48);
            push_button_n = 1'b0;
            n = 0;
            while (push_button_reset !== 1'b1 && n < 100)
                @(negedge mclk) n++;
            `CHK("hold", 1'b1, n >= (t ? HOLD_LONG : HOLD_SHORT)
                && n <= (t ? HOLD_LONG : HOLD_SHORT) + 3)
            push_button_n = 1'b1;
        end
        repeat (4) @(negedge mclk);
        summarize();
    end
endmodule : tb_top
bind pec_regs pec_regs_props #(.RESET_SHORT(RESET_SHORT)) pec_regs_props_i (.mclk, .reset_n,
    .reg_rd, .reg_addr, .reg_rdata, .push_button_n, .rails_good, .first_gp_pin_o,
    .second_gp_output_o, .second_gp_output_oe, .second_gp_output_push_pull, .power_good,
    .push_button_reset, .supervisor_strictness, .overvoltage_monitor_en);
